// *** rtl/probe_pin_mux.sv ***
`timescale 1ns/1ps
module probe_pin_mux import probe_pkg::*; (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enable,
  input wire pin_cfg_t cfg,
  input wire probe_sigs_t sigs,
  input wire logic carrier,
  output logic pin_out
);

  logic out_reg;
  logic out_next;
  logic [7:0] grp_bits;

  // ----------------------------------------------------------------
  // signal selection
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.grp)
      GRP_TIMER: grp_bits = {sigs.timer[7:2], 2'b00};
      GRP_CARD: grp_bits = sigs.card;
      GRP_XCV: grp_bits = sigs.xcv;
      GRP_RXD: grp_bits = sigs.rxd;
      GRP_ERR: grp_bits = {sigs.err[7:6], 3'b000, sigs.err[2:0]};
      default: grp_bits = 8'h00;
    endcase
    out_next = 1'b0;
    if (enable && cfg.grp != GRP_NONE) begin
      if (cfg.sel == SEL_CARRIER) begin
        out_next = carrier;
      end else if (cfg.sel < SEL_CARRIER) begin
        out_next = grp_bits[cfg.sel[2:0]];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  enable_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    !enable |=> !pin_out) else $error("pin driven while test bus disabled");
  timer_run_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp == GRP_TIMER && cfg.sel == 4'h7) |=> pin_out == $past(sigs.timer[7]))
    else $error("timer zero running flag not routed");
  timer_rsvd_a: assert property (@(posedge ref_clk) disable iff (srst)
    (cfg.grp == GRP_TIMER && cfg.sel < 4'h2) |=> !pin_out) else $error("reserved timer code not low");
  carrier_route_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp != GRP_NONE && cfg.sel == SEL_CARRIER) |=> pin_out == $past(carrier))
    else $error("carrier not routed on code 8");
  card_typeb_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp == GRP_CARD && cfg.sel == 4'h3) |=> pin_out == $past(sigs.card[3]))
    else $error("card mode code 3 wrong");
  xcv_start_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp == GRP_XCV && cfg.sel == 4'h5) |=> pin_out == $past(sigs.xcv[5]))
    else $error("transceive code 5 wrong");
  rxd_status_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp == GRP_RXD && cfg.sel == 4'h3) |=> pin_out == $past(sigs.rxd[3]))
    else $error("receiver data code 3 wrong");
  err_length_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && cfg.grp == GRP_ERR && cfg.sel == 4'h6) |=> pin_out == $past(sigs.err[6]))
    else $error("receiver error code 6 wrong");
  reserved_low_a: assert property (@(posedge ref_clk) disable iff (srst)
    (cfg.sel > SEL_CARRIER || (cfg.grp == GRP_ERR && cfg.sel inside {[4'h3:4'h5]})) |=> !pin_out)
    else $error("reserved code not driven low");

endmodule

// *** rtl/probe_pkg.sv ***
package probe_pkg;

  // ----------------------------------------------------------------
  // command codes and parameter fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DIGITAL = 8'h18;
  localparam logic [7:0] CMD_ANALOG = 8'h19;
  localparam logic [7:0] GRP_CODE_TIMER = 8'h1d;
  localparam logic [7:0] GRP_CODE_CARD = 8'h30;
  localparam logic [7:0] GRP_CODE_XCV = 8'h58;
  localparam logic [7:0] GRP_CODE_RXD = 8'h70;
  localparam logic [7:0] GRP_CODE_ERR = 8'h73;
  localparam int POS_PIN_LSB = 4;
  localparam int POS_SEL_LSB = 0;
  localparam logic [2:0] MAX_POS_BYTES = 3'h4;

  // ----------------------------------------------------------------
  // output pins, select codes, nonvolatile enable
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 4;
  localparam logic [3:0] PIN_IRQ = 4'h0;
  localparam logic [3:0] PIN_AUX_ONE = 4'h1;
  localparam logic [3:0] PIN_AUX_TWO = 4'h2;
  localparam logic [3:0] PIN_GPO = 4'h3;
  localparam logic [3:0] SEL_CARRIER = 4'h8;
  localparam logic [7:0] NV_ENABLE_ADDR = 8'h17;
  localparam int NV_ENABLE_BIT = 7;
  localparam logic [7:0] ANA_RESERVED = 8'h08;
  localparam logic [7:0] ANA_MAX = 8'h0a;
  localparam logic [3:0] ANA_SEL_RST = 4'h0;

  typedef enum logic [2:0] {
    GRP_NONE = 3'b000,
    GRP_TIMER = 3'b001,
    GRP_CARD = 3'b010,
    GRP_XCV = 3'b011,
    GRP_RXD = 3'b100,
    GRP_ERR = 3'b101
  } grp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GROUP = 3'b001,
    ST_POS = 3'b010,
    ST_ANA_TWO = 3'b011,
    ST_ANA_ONE = 3'b100
  } parse_state_t;

  typedef struct packed {
    grp_t grp;
    logic [3:0] sel;
  } pin_cfg_t;

  localparam pin_cfg_t PIN_CFG_RST = '{grp: GRP_NONE, sel: 4'h0};

  // internal debug signals, one byte per group, bit index = select code
  typedef struct packed {
    logic [7:0] timer;
    logic [7:0] card;
    logic [7:0] xcv;
    logic [7:0] rxd;
    logic [7:0] err;
  } probe_sigs_t;

endpackage

// *** rtl/test_signal_multiplexer.sv ***
`timescale 1ns/1ps
module test_signal_multiplexer import probe_pkg::*; (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] nv_testbus_cfg,
  input wire probe_sigs_t probe_sigs,
  input wire logic carrier_clk_pin,
  output logic [NUM_PINS-1:0] probe_pin_out,
  output logic [3:0] aux_pin_one_sel,
  output logic [3:0] aux_pin_two_sel,
  output logic aux_pin_one_valid,
  output logic aux_pin_two_valid,
  output logic cmd_busy,
  output logic debug_output_enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  parse_state_t state_reg, state_next;
  grp_t grp_hold_reg, grp_hold_next;
  logic [2:0] pos_cnt_reg, pos_cnt_next;
  logic [7:0] ana_two_hold_reg, ana_two_hold_next;
  pin_cfg_t cfg_reg [NUM_PINS];
  pin_cfg_t cfg_next [NUM_PINS];
  logic [3:0] ana_one_reg, ana_one_next;
  logic [3:0] ana_two_reg, ana_two_next;
  logic ana_one_ok_reg, ana_one_ok_next;
  logic ana_two_ok_reg, ana_two_ok_next;
  logic aux_one_valid_reg, aux_one_valid_next;
  logic aux_two_valid_reg, aux_two_valid_next;
  logic busy_reg, busy_next;
  logic enable_reg, enable_next;
  logic carrier_meta_reg, carrier_sync_reg;
  logic param;
  logic [1:0] pin_idx;

  function automatic grp_t grp_decode(input logic [7:0] code);
    case (code)
      GRP_CODE_TIMER: grp_decode = GRP_TIMER;
      GRP_CODE_CARD: grp_decode = GRP_CARD;
      GRP_CODE_XCV: grp_decode = GRP_XCV;
      GRP_CODE_RXD: grp_decode = GRP_RXD;
      GRP_CODE_ERR: grp_decode = GRP_ERR;
      default: grp_decode = GRP_NONE;
    endcase
  endfunction

  // analog selects above a, the reserved 8 and set upper bits are refused
  function automatic logic ana_ok(input logic [7:0] code);
    ana_ok = (code <= ANA_MAX) && (code != ANA_RESERVED);
  endfunction

  assign param = cmd_valid && !cmd_first;
  assign pin_idx = cmd_byte[POS_PIN_LSB +: 2];

  // ----------------------------------------------------------------
  // command parser
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    grp_hold_next = grp_hold_reg;
    pos_cnt_next = pos_cnt_reg;
    ana_two_hold_next = ana_two_hold_reg;
    cfg_next = cfg_reg;
    ana_one_next = ana_one_reg;
    ana_two_next = ana_two_reg;
    ana_one_ok_next = ana_one_ok_reg;
    ana_two_ok_next = ana_two_ok_reg;
    busy_next = 1'b0;
    if (cmd_valid && cmd_first) begin
      // a new frame always restarts parsing, so a truncated one is harmless
      case (cmd_byte)
        CMD_DIGITAL: state_next = ST_GROUP;
        CMD_ANALOG: state_next = ST_ANA_TWO;
        default: state_next = ST_IDLE;
      endcase
    end else if (param) begin
      case (state_reg)
        ST_GROUP: begin
          grp_hold_next = grp_decode(cmd_byte);
          pos_cnt_next = 3'h0;
          state_next = ST_POS;
        end
        ST_POS: begin
          if (cmd_byte[7:POS_PIN_LSB] < 4'(NUM_PINS)) begin
            cfg_next[pin_idx] = '{grp: grp_hold_reg, sel: cmd_byte[POS_SEL_LSB +: 4]};
            if (cmd_byte[7:POS_PIN_LSB] == PIN_AUX_ONE) begin
              ana_one_ok_next = 1'b0;
            end
            if (cmd_byte[7:POS_PIN_LSB] == PIN_AUX_TWO) begin
              ana_two_ok_next = 1'b0;
            end
          end
          pos_cnt_next = pos_cnt_reg + 3'h1;
          if (pos_cnt_reg == MAX_POS_BYTES - 3'h1) begin
            state_next = ST_IDLE;
          end
        end
        ST_ANA_TWO: begin
          ana_two_hold_next = cmd_byte;
          state_next = ST_ANA_ONE;
        end
        ST_ANA_ONE: begin
          ana_one_next = cmd_byte[3:0];
          ana_two_next = ana_two_hold_reg[3:0];
          ana_one_ok_next = ana_ok(cmd_byte);
          ana_two_ok_next = ana_ok(ana_two_hold_reg);
          cfg_next[PIN_AUX_ONE[1:0]] = PIN_CFG_RST;
          cfg_next[PIN_AUX_TWO[1:0]] = PIN_CFG_RST;
          busy_next = 1'b1;
          state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------
  always_comb begin
    enable_next = nv_testbus_cfg[NV_ENABLE_BIT];
    aux_one_valid_next = enable_reg && ana_one_ok_reg;
    aux_two_valid_next = enable_reg && ana_two_ok_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      grp_hold_reg <= GRP_NONE;
      pos_cnt_reg <= 3'h0;
      ana_two_hold_reg <= 8'h00;
      cfg_reg <= '{default: PIN_CFG_RST};
      ana_one_reg <= ANA_SEL_RST;
      ana_two_reg <= ANA_SEL_RST;
      ana_one_ok_reg <= 1'b0;
      ana_two_ok_reg <= 1'b0;
      aux_one_valid_reg <= 1'b0;
      aux_two_valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      enable_reg <= 1'b0;
      carrier_meta_reg <= 1'b0;
      carrier_sync_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      grp_hold_reg <= grp_hold_next;
      pos_cnt_reg <= pos_cnt_next;
      ana_two_hold_reg <= ana_two_hold_next;
      cfg_reg <= cfg_next;
      ana_one_reg <= ana_one_next;
      ana_two_reg <= ana_two_next;
      ana_one_ok_reg <= ana_one_ok_next;
      ana_two_ok_reg <= ana_two_ok_next;
      aux_one_valid_reg <= aux_one_valid_next;
      aux_two_valid_reg <= aux_two_valid_next;
      busy_reg <= busy_next;
      enable_reg <= enable_next;
      // the carrier arrives from another clock; sampling limits its fidelity
      carrier_meta_reg <= carrier_clk_pin;
      carrier_sync_reg <= carrier_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin multiplexers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    probe_pin_mux u_mux (
      .ref_clk(ref_clk),
      .srst(srst),
      .enable(enable_reg),
      .cfg(cfg_reg[p]),
      .sigs(probe_sigs),
      .carrier(carrier_sync_reg),
      .pin_out(probe_pin_out[p])
    );
  end

  assign aux_pin_one_sel = ana_one_reg;
  assign aux_pin_two_sel = ana_two_reg;
  assign aux_pin_one_valid = aux_one_valid_reg;
  assign aux_pin_two_valid = aux_two_valid_reg;
  assign cmd_busy = busy_reg;
  assign debug_output_enable = enable_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  analog_apply_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ANA_ONE && param) |=>
      (aux_pin_one_sel == $past(cmd_byte[3:0]) && aux_pin_two_sel == $past(ana_two_hold_reg[3:0])))
    else $error("analog selects not applied in order");
  analog_busy_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ANA_ONE && param) |=> cmd_busy ##1 !cmd_busy) else $error("busy pulse missing");
  analog_rsvd_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ANA_ONE && param && cmd_byte == ANA_RESERVED) |=> ##1 !aux_pin_one_valid)
    else $error("reserved analog select accepted");
  analog_good_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ANA_ONE && param && cmd_byte == 8'h09 && enable_reg) ##1 enable_reg
      |=> aux_pin_one_valid) else $error("valid analog select refused");
  enable_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    !enable_reg |=> (!aux_pin_one_valid && !aux_pin_two_valid)) else $error("analog out while disabled");
  pos_apply_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_POS && param && cmd_byte[7:4] == PIN_GPO) |=>
      (cfg_reg[3].sel == $past(cmd_byte[3:0]) && cfg_reg[3].grp == $past(grp_hold_reg)))
    else $error("pin position byte not applied");
  pos_limit_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_POS && param && pos_cnt_reg == 3'h3) |=> state_reg == ST_IDLE)
    else $error("more than four position bytes accepted");
  grp_map_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_GROUP && param && cmd_byte == GRP_CODE_XCV) |=> grp_hold_reg == GRP_XCV)
    else $error("group code mapped wrongly");

endmodule

// *** sim/host_cmd_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side command source
// ----------------------------------------------------------------
module host_cmd_model import probe_pkg::*; (
  input wire logic ref_clk,
  input wire logic cmd_busy,
  output logic cmd_valid,
  output logic cmd_first,
  output logic [7:0] cmd_byte,
  output logic busy_timeout
);
  initial begin
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_byte = 8'h00;
    busy_timeout = 1'b0;
  end

  // one strobe per byte, back to back; the released byte is inverted so stale data never looks valid
  task automatic send(input logic [7:0] b[$]);
    int n;
    for (int i = 0; i < b.size(); i++) begin
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_first = (i == 0);
      cmd_byte = b[i];
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_byte = ~cmd_byte;
    if (b[0] == CMD_ANALOG && b.size() == 3) begin
      // no further traffic until the busy indication shows, bounded so a dead design cannot hang us
      n = 0;
      while (cmd_busy !== 1'b1 && n < 8) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      if (n == 8) busy_timeout = 1'b1;
    end
  endtask
endmodule

// *** sim/test_signal_multiplexer_tb.sv ***
`timescale 1ns/1ps
module test_signal_multiplexer_tb import probe_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic srst;
  logic [7:0] nv_testbus_cfg;
  probe_sigs_t probe_sigs;
  logic carrier_clk_pin;
  logic cmd_valid, cmd_first, cmd_busy, busy_timeout;
  logic [7:0] cmd_byte;
  logic [NUM_PINS-1:0] probe_pin_out;
  logic [3:0] aux_pin_one_sel, aux_pin_two_sel;
  logic aux_pin_one_valid, aux_pin_two_valid, debug_output_enable;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] pat;
  logic [7:0] fr[$];
  // last entry is a group this block does not carry
  logic [7:0] grp_codes [6] = '{GRP_CODE_TIMER, GRP_CODE_CARD, GRP_CODE_XCV, GRP_CODE_RXD, GRP_CODE_ERR, 8'h01};

  always #2.5 ref_clk = ~ref_clk;

  test_signal_multiplexer DUT (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
    .cmd_byte(cmd_byte), .nv_testbus_cfg(nv_testbus_cfg), .probe_sigs(probe_sigs),
    .carrier_clk_pin(carrier_clk_pin), .probe_pin_out(probe_pin_out), .aux_pin_one_sel(aux_pin_one_sel),
    .aux_pin_two_sel(aux_pin_two_sel), .aux_pin_one_valid(aux_pin_one_valid),
    .aux_pin_two_valid(aux_pin_two_valid), .cmd_busy(cmd_busy), .debug_output_enable(debug_output_enable));

  host_cmd_model host (.ref_clk(ref_clk), .cmd_busy(cmd_busy), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
    .cmd_byte(cmd_byte), .busy_timeout(busy_timeout));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // pin level expected for group index gi, select s, target pattern p (carrier follows p[1])
  // carrier differs from bit 0 so a stray code 8 on a pin set to code 0 shows up
  function automatic logic exp_pin(input int gi, input logic [3:0] s, input logic [7:0] p);
    if (gi == 5) return 1'b0;
    if (s == SEL_CARRIER) return p[1];
    if (s > SEL_CARRIER) return 1'b0;
    if (gi == 0 && s < 4'h2) return 1'b0;
    if (gi == 4 && s >= 4'h3 && s <= 4'h5) return 1'b0;
    return p[s[2:0]];
  endfunction

  function automatic logic ana_ok(input logic [7:0] x);
    return x <= ANA_MAX && x != ANA_RESERVED;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    nv_testbus_cfg = 8'h00;
    probe_sigs = '0;
    carrier_clk_pin = 1'b0;
    wait_n(6);
    check(probe_pin_out, 16'h0000);
    check({aux_pin_one_sel, aux_pin_two_sel, aux_pin_one_valid, aux_pin_two_valid}, 16'h0000);
    srst = 1'b0;
    nv_testbus_cfg = 8'h80;
    wait_n(3);
    check(debug_output_enable, 16'h0001);
    // analog selects, codes 0 to 11 once on each aux pin, reversed pairing
    for (int v = 0; v < 12; v++) begin
      host.send('{CMD_ANALOG, 8'(v), 8'(11 - v)});
      wait_n(3);
      check({aux_pin_two_sel, aux_pin_one_sel}, 16'({4'(v), 4'(11 - v)}));
      check({aux_pin_two_valid, aux_pin_one_valid}, 16'({ana_ok(8'(v)), ana_ok(8'(11 - v))}));
      check(cmd_busy, 16'h0000);
    end
    // a cut analog frame applies nothing
    host.send('{CMD_ANALOG, 8'h05});
    host.send('{CMD_DIGITAL, GRP_CODE_TIMER, 8'h37});
    wait_n(3);
    check({aux_pin_two_sel, aux_pin_one_sel}, 16'h00b0);
    // every group, each select on one pin (pin p takes 4*q+p), two patterns; a fifth position byte must be ignored
    for (int gi = 0; gi < 6; gi++) begin
      for (int pi = 0; pi < 2; pi++) begin
        for (int q = 0; q < 4; q++) begin
          pat = pi ? 8'h5a : 8'ha5;
          probe_sigs = probe_sigs_t'({5{~pat}});
          if (gi < 5) probe_sigs[39-8*gi -: 8] = pat;
          carrier_clk_pin = pat[1];
          fr = '{CMD_DIGITAL, grp_codes[gi]};
          for (int p = 0; p < 4; p++) fr.push_back(8'(16 * p + 4 * q + p));
          fr.push_back(8'h08);
          host.send(fr);
          wait_n(6);
          for (int p = 0; p < 4; p++) begin
            check(probe_pin_out[p], exp_pin(gi, 4'(4*q+p), pat));
          end
        end
      end
    end
    // enable removed: pins and the enable copy drop, the valids stay low
    probe_sigs = probe_sigs_t'({5{8'hff}});
    host.send('{CMD_DIGITAL, GRP_CODE_TIMER, 8'h07, 8'h17, 8'h27, 8'h37});
    // an unknown opcode and an out-of-range pin nibble must both leave the pins alone
    host.send('{8'h42, GRP_CODE_TIMER, 8'h00});
    host.send('{CMD_DIGITAL, GRP_CODE_TIMER, 8'h40});
    wait_n(4);
    check(probe_pin_out, 16'h000f);
    check({aux_pin_one_valid, aux_pin_two_valid}, 16'h0000);
    nv_testbus_cfg = 8'h7f;
    wait_n(3);
    check({probe_pin_out, debug_output_enable, aux_pin_one_valid, aux_pin_two_valid}, 16'h0000);
    check(busy_timeout, 16'h0000);
    stop_test();
  end
endmodule
